/* File: logic/rkw_map.vh */
// Address map, field positions and reset values of the wake and config register bank
`ifndef RKW_MAP_VH
`define RKW_MAP_VH

// ****************************************************************
// Address = {logical device number, configuration index}
// ****************************************************************
`define RKW_LDN_CLOCK        8'h06
`define RKW_LDN_KBD          8'h07
`define RKW_LDN_AUX          8'h08
`define RKW_IDX_MODE         8'hF0
`define RKW_IDX_KBD_RSV_LO   8'hF1
`define RKW_IDX_KBD_RSV_HI   8'hFF
`define RKW_IDX_WAKE_EN1     8'hB0
`define RKW_IDX_WAKE_STAT1   8'hB2

// ****************************************************************
// Reset values
// ****************************************************************
`define RKW_RST_CLK_MODE     8'h00
`define RKW_RST_KBD_SEL      8'h00
`define RKW_RST_WAKE_EN1     8'h00
`define RKW_RST_WAKE_STAT1   8'h00

// ****************************************************************
// Clock mode register fields
// ****************************************************************
`define RKW_MODE_LOCK_LSB    0
`define RKW_MODE_LOCK_MSB    3
`define RKW_MODE_BANK_LSB    4
`define RKW_MODE_BANK_MSB    5
`define RKW_BANK_UP_ONLY     2'h0
`define RKW_BANK_BOTH        2'h1
`define RKW_BANK_NONE        2'h2
`define RKW_BANK_LOW_ONLY    2'h3
`define RKW_LOWER_BANK_BASE  8'h70
`define RKW_CMOS_BLK_MSB     6
`define RKW_CMOS_BLK_LSB     5

// ****************************************************************
// Keyboard select register fields
// ****************************************************************
`define RKW_KBD_RST_HW_BIT   0
`define RKW_KBD_A20_HW_BIT   1
`define RKW_KBD_P92_EN_BIT   2
`define RKW_KBD_P12_POL_BIT  7

// ****************************************************************
// Wake enable and status bit positions
// ****************************************************************
`define RKW_WK_RING_ONE      0
`define RKW_WK_RING_TWO      1
`define RKW_WK_KBD_CLOCK     2
`define RKW_WK_MOUSE_CLOCK   3
`define RKW_WK_GROUP_ONE     4
`define RKW_WK_GROUP_TWO     5
`define RKW_WK_IR_RECEIVE    6
`define RKW_WK_CLOCK_ALARM   7

`endif

/* File: logic/rkw_sync2.v */
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module rkw_sync2 #(
    parameter W    = 1,
    parameter INIT = 1'b1
) (
    input  wire         i_mclk,
    input  wire         i_rst_n,
    input  wire         i_ce,
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // Idle pins rest high, so reset to high avoids a false fall at release
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= {W{INIT}};
            sync_reg <= {W{INIT}};
        end else if (i_ce) begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule
`default_nettype wire

/* File: logic/rkw_wake_latch.v */
// Sticky wake status bit: set on a falling edge or a high level, cleared by a status read
`timescale 1ns/1ps
`default_nettype none
module rkw_wake_latch #(
    parameter FALL = 1
) (
    input  wire i_mclk,
    input  wire i_rst_n,
    input  wire i_ce,
    input  wire i_level,
    input  wire i_clr,
    output wire o_flag
);
    reg  prev_reg;
    reg  flag_reg;
    wire set_evt;
    wire flag_next;

    assign set_evt   = FALL ? (prev_reg & ~i_level) : i_level;
    // Set wins over a clear in the same cycle so no event is lost
    assign flag_next = set_evt | (flag_reg & ~i_clr);

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_reg <= 1'b1;
            flag_reg <= 1'b0;
        end else if (i_ce) begin
            prev_reg <= i_level;
            flag_reg <= flag_next;
        end
    end

    assign o_flag = flag_reg;
endmodule
`default_nettype wire

/* File: logic/rkw_cfg_regs.v */
// Clock CMOS, keyboard select and wake enable configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "rkw_map.vh"
module rkw_cfg_regs #(
    parameter AW = 16,
    parameter DW = 8
) (
    input  wire          i_mclk,
    input  wire          i_rst_n,
    input  wire          i_vbat_rst_n,
    input  wire          i_ce,
    // Register port
    input  wire [AW-1:0] i_addr,
    input  wire [DW-1:0] i_wdata,
    input  wire          i_wr,
    input  wire          i_rd,
    output wire [DW-1:0] o_rdata,
    // CMOS access qualification
    input  wire          i_cmos_wr,
    input  wire          i_cmos_rd,
    input  wire          i_cmos_upper,
    input  wire [6:0]    i_cmos_off,
    output wire          o_cmos_wr_ok,
    output wire          o_cmos_rd_ok,
    output wire          o_lower_bank_en,
    output wire [7:0]    o_lower_bank_base,
    output wire          o_upper_bank_en,
    // Keyboard controller hooks
    input  wire          i_kbd_reset_assert,
    output wire          o_kbd_port_line_twelve,
    output wire          o_port92_en,
    output wire          o_addr20_gate_hw,
    output wire          o_keyboard_reset_hw,
    // Wake sources
    input  wire          i_ring_one_n,
    input  wire          i_ring_two_n,
    input  wire          i_kbd_clock,
    input  wire          i_mouse_clock,
    input  wire          i_ir_receive_pin,
    input  wire          i_group_int_one,
    input  wire          i_group_int_two,
    input  wire          i_clock_alarm,
    output wire          o_power_on_request_n
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire [7:0] ldn;
    wire [7:0] idx;
    wire       hit_mode;
    wire       hit_kbd;
    wire       hit_kbd_rsv;
    wire       hit_wake_en;
    wire       hit_wake_st;

    assign ldn         = i_addr[15:8];
    assign idx         = i_addr[7:0];
    assign hit_mode    = (ldn == `RKW_LDN_CLOCK) && (idx == `RKW_IDX_MODE);
    assign hit_kbd     = (ldn == `RKW_LDN_KBD) && (idx == `RKW_IDX_MODE);
    assign hit_kbd_rsv = (ldn == `RKW_LDN_KBD) && (idx >= `RKW_IDX_KBD_RSV_LO)
                         && (idx <= `RKW_IDX_KBD_RSV_HI);
    assign hit_wake_en = (ldn == `RKW_LDN_AUX) && (idx == `RKW_IDX_WAKE_EN1);
    assign hit_wake_st = (ldn == `RKW_LDN_AUX) && (idx == `RKW_IDX_WAKE_STAT1);

    // ****************************************************************
    // Clock mode register (main supply reset)
    // ****************************************************************
    reg  [3:0] lock_reg;
    reg  [3:0] lock_next;
    reg  [1:0] bank_reg;
    reg  [1:0] bank_next;
    // Constant, so the asynchronous reset branch loads no logic
    localparam [7:0] mode_rst = `RKW_RST_CLK_MODE;

    always @* begin
        lock_next = lock_reg;
        bank_next = bank_reg;
        if (i_wr && hit_mode) begin
            // Writing zero cannot unlock a block
            lock_next = lock_reg | i_wdata[`RKW_MODE_LOCK_MSB:`RKW_MODE_LOCK_LSB];
            bank_next = i_wdata[`RKW_MODE_BANK_MSB:`RKW_MODE_BANK_LSB];
        end
    end

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock_reg <= mode_rst[`RKW_MODE_LOCK_MSB:`RKW_MODE_LOCK_LSB];
            bank_reg <= mode_rst[`RKW_MODE_BANK_MSB:`RKW_MODE_BANK_LSB];
        end else if (i_ce) begin
            lock_reg <= lock_next;
            bank_reg <= bank_next;
        end
    end

    // ****************************************************************
    // Bank mapping
    // ****************************************************************
    reg lower_en_reg;
    reg upper_en_reg;
    reg lower_en_next;
    reg upper_en_next;

    always @* begin
        case (bank_next)
            `RKW_BANK_UP_ONLY: begin
                lower_en_next = 1'b0;
                upper_en_next = 1'b1;
            end
            `RKW_BANK_BOTH: begin
                lower_en_next = 1'b1;
                upper_en_next = 1'b1;
            end
            `RKW_BANK_NONE: begin
                lower_en_next = 1'b0;
                upper_en_next = 1'b0;
            end
            `RKW_BANK_LOW_ONLY: begin
                lower_en_next = 1'b1;
                upper_en_next = 1'b0;
            end
            default: begin
                lower_en_next = 1'b0;
                upper_en_next = 1'b0;
            end
        endcase
    end

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lower_en_reg <= 1'b0;
            upper_en_reg <= 1'b1;
        end else if (i_ce) begin
            lower_en_reg <= lower_en_next;
            upper_en_reg <= upper_en_next;
        end
    end

    assign o_lower_bank_en   = lower_en_reg;
    assign o_upper_bank_en   = upper_en_reg;
    assign o_lower_bank_base = `RKW_LOWER_BANK_BASE;

    // ****************************************************************
    // CMOS lock gating
    // ****************************************************************
    // Combinational so a locked access is dropped in the cycle it arrives
    wire [1:0] cmos_blk;
    wire       blk_locked;

    assign cmos_blk     = i_cmos_off[`RKW_CMOS_BLK_MSB:`RKW_CMOS_BLK_LSB];
    assign blk_locked   = i_cmos_upper & lock_reg[cmos_blk];
    assign o_cmos_wr_ok = i_cmos_wr & ~blk_locked;
    assign o_cmos_rd_ok = i_cmos_rd & ~blk_locked;

    // ****************************************************************
    // Keyboard select register
    // ****************************************************************
    reg  [7:0] kbd_sel_reg;
    reg        p12_reg;
    wire       p12_next;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            kbd_sel_reg <= `RKW_RST_KBD_SEL;
        end else if (i_ce && i_wr && hit_kbd) begin
            kbd_sel_reg <= i_wdata;
        end
    end

    // Low polarity drives the line low while reset is asserted
    assign p12_next = kbd_sel_reg[`RKW_KBD_P12_POL_BIT] ? i_kbd_reset_assert
                                                        : ~i_kbd_reset_assert;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            p12_reg <= 1'b1;
        end else if (i_ce) begin
            p12_reg <= p12_next;
        end
    end

    assign o_kbd_port_line_twelve = p12_reg;
    assign o_port92_en            = kbd_sel_reg[`RKW_KBD_P92_EN_BIT];
    assign o_addr20_gate_hw       = kbd_sel_reg[`RKW_KBD_A20_HW_BIT];
    assign o_keyboard_reset_hw    = kbd_sel_reg[`RKW_KBD_RST_HW_BIT];

    // ****************************************************************
    // Wake enable register (battery reset only)
    // ****************************************************************
    reg [7:0] wake_en_reg;

    always @(posedge i_mclk or negedge i_vbat_rst_n) begin
        if (!i_vbat_rst_n) begin
            wake_en_reg <= `RKW_RST_WAKE_EN1;
        end else if (i_ce && i_wr && hit_wake_en) begin
            wake_en_reg <= i_wdata;
        end
    end

    // ****************************************************************
    // Wake status sources
    // ****************************************************************
    wire [4:0] pin_sync;
    wire [7:0] wake_st;
    wire       st_clr;
    wire [4:0] pin_idx_lvl;

    assign st_clr = i_rd & hit_wake_st;

    rkw_sync2 #(
        .W    (5),
        .INIT (1'b1)
    ) u_pin_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_vbat_rst_n),
        .i_ce    (i_ce),
        .i_async ({i_ir_receive_pin, i_mouse_clock, i_kbd_clock,
                   i_ring_two_n, i_ring_one_n}),
        .o_sync  (pin_sync)
    );

    assign pin_idx_lvl = pin_sync;

    rkw_wake_latch #(.FALL(1)) u_lat_ring1 (
        .i_mclk  (i_mclk),
        .i_rst_n (i_vbat_rst_n),
        .i_ce    (i_ce),
        .i_level (pin_idx_lvl[0]),
        .i_clr   (st_clr),
        .o_flag  (wake_st[`RKW_WK_RING_ONE])
    );

    rkw_wake_latch #(.FALL(1)) u_lat_ring2 (
        .i_mclk  (i_mclk),
        .i_rst_n (i_vbat_rst_n),
        .i_ce    (i_ce),
        .i_level (pin_idx_lvl[1]),
        .i_clr   (st_clr),
        .o_flag  (wake_st[`RKW_WK_RING_TWO])
    );

    rkw_wake_latch #(.FALL(1)) u_lat_kclk (
        .i_mclk  (i_mclk),
        .i_rst_n (i_vbat_rst_n),
        .i_ce    (i_ce),
        .i_level (pin_idx_lvl[2]),
        .i_clr   (st_clr),
        .o_flag  (wake_st[`RKW_WK_KBD_CLOCK])
    );

    rkw_wake_latch #(.FALL(1)) u_lat_mclk (
        .i_mclk  (i_mclk),
        .i_rst_n (i_vbat_rst_n),
        .i_ce    (i_ce),
        .i_level (pin_idx_lvl[3]),
        .i_clr   (st_clr),
        .o_flag  (wake_st[`RKW_WK_MOUSE_CLOCK])
    );

    rkw_wake_latch #(.FALL(1)) u_lat_irrx (
        .i_mclk  (i_mclk),
        .i_rst_n (i_vbat_rst_n),
        .i_ce    (i_ce),
        .i_level (pin_idx_lvl[4]),
        .i_clr   (st_clr),
        .o_flag  (wake_st[`RKW_WK_IR_RECEIVE])
    );

    // Alarm is on-chip: no synchroniser, level sets the sticky bit
    rkw_wake_latch #(.FALL(0)) u_lat_alarm (
        .i_mclk  (i_mclk),
        .i_rst_n (i_vbat_rst_n),
        .i_ce    (i_ce),
        .i_level (i_clock_alarm),
        .i_clr   (st_clr),
        .o_flag  (wake_st[`RKW_WK_CLOCK_ALARM])
    );

    // Group interrupts are cleared at their source, so they pass live
    assign wake_st[`RKW_WK_GROUP_ONE] = i_group_int_one;
    assign wake_st[`RKW_WK_GROUP_TWO] = i_group_int_two;

    // ****************************************************************
    // Power-on request
    // ****************************************************************
    reg pwr_req_n_reg;

    always @(posedge i_mclk or negedge i_vbat_rst_n) begin
        if (!i_vbat_rst_n) begin
            pwr_req_n_reg <= 1'b1;
        end else if (i_ce) begin
            pwr_req_n_reg <= ~|(wake_st & wake_en_reg);
        end
    end

    assign o_power_on_request_n = pwr_req_n_reg;

    // ****************************************************************
    // Read path
    // ****************************************************************
    reg [DW-1:0] rdata_reg;
    reg [DW-1:0] rdata_next;

    always @* begin
        rdata_next = {DW{1'b0}};
        if (hit_mode) begin
            rdata_next = {2'h0, bank_reg, lock_reg};
        end else if (hit_kbd) begin
            rdata_next = kbd_sel_reg;
        end else if (hit_kbd_rsv) begin
            rdata_next = {DW{1'b0}};
        end else if (hit_wake_en) begin
            rdata_next = wake_en_reg;
        end else if (hit_wake_st) begin
            rdata_next = wake_st;
        end
    end

    // Data stands only in the cycle after the strobe
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= {DW{1'b0}};
        end else if (i_ce) begin
            rdata_reg <= i_rd ? rdata_next : {DW{1'b0}};
        end
    end

    assign o_rdata = rdata_reg;

endmodule
`default_nettype wire

/* File: dv/rkw_cfg_regs_properties.sv */
// Port-level assertions for the clock, keyboard and wake config registers
`timescale 1ns/1ps
`default_nettype none
`include "rkw_map.vh"
module rkw_cfg_regs_properties #(
    parameter AW = 16,
    parameter DW = 8
) (
    input wire logic          i_mclk,
    input wire logic          i_rst_n,
    input wire logic          i_vbat_rst_n,
    input wire logic          i_ce,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic          i_wr,
    input wire logic          i_rd,
    input wire logic [DW-1:0] o_rdata,
    input wire logic          i_cmos_wr,
    input wire logic          i_cmos_rd,
    input wire logic          i_cmos_upper,
    input wire logic [6:0]    i_cmos_off,
    input wire logic          o_cmos_wr_ok,
    input wire logic          o_cmos_rd_ok,
    input wire logic          o_lower_bank_en,
    input wire logic          o_upper_bank_en,
    input wire logic          i_kbd_reset_assert,
    input wire logic          o_kbd_port_line_twelve,
    input wire logic          o_port92_en,
    input wire logic          o_addr20_gate_hw,
    input wire logic          o_keyboard_reset_hw,
    input wire logic          i_ring_one_n,
    input wire logic          i_clock_alarm,
    input wire logic          o_power_on_request_n
);
    // ********
    // Shadow state
    // ********
    wire       cw      = i_ce && i_wr;
    wire       mode_wr = cw && i_addr == {`RKW_LDN_CLOCK, `RKW_IDX_MODE};
    wire       kbd_wr  = cw && i_addr == {`RKW_LDN_KBD, `RKW_IDX_MODE};
    wire       en_wr   = cw && i_addr == {`RKW_LDN_AUX, `RKW_IDX_WAKE_EN1};
    wire       rsv_rd  = i_ce && i_rd && i_addr[15:8] == `RKW_LDN_KBD
                         && i_addr[7:0] >= `RKW_IDX_KBD_RSV_LO;
    logic [3:0] lock_reg;
    logic       pol_reg;
    logic [7:0] en_reg;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock_reg <= 4'h0;
            pol_reg <= 1'b0;
        end else if (mode_wr) begin
            lock_reg <= lock_reg | i_wdata[3:0];
        end else if (kbd_wr) begin
            pol_reg <= i_wdata[7];
        end
    end

    // Wake enables live on the battery reset only
    always @(posedge i_mclk or negedge i_vbat_rst_n) begin
        if (!i_vbat_rst_n) begin
            en_reg <= 8'h00;
        end else if (en_wr) begin
            en_reg <= i_wdata;
        end
    end

    // ********
    // Assertions
    // ********
    default clocking cb @(posedge i_mclk); endclocking

    property p_bank;
        disable iff (!i_rst_n)
        mode_wr |=> o_upper_bank_en == !$past(i_wdata[5])
            && o_lower_bank_en == $past(i_wdata[4]);
    endproperty

    property p_kbd;
        disable iff (!i_rst_n)
        kbd_wr |=>
            {o_port92_en, o_addr20_gate_hw, o_keyboard_reset_hw} == $past(i_wdata[2:0]);
    endproperty

    chk_lock_wr_gate: assert property (disable iff (!i_rst_n)
        o_cmos_wr_ok == (i_cmos_wr && !(i_cmos_upper && lock_reg[i_cmos_off[6:5]])))
        else $error("cmos write gate wrong");
    chk_lock_rd_gate: assert property (disable iff (!i_rst_n)
        o_cmos_rd_ok == (i_cmos_rd && !(i_cmos_upper && lock_reg[i_cmos_off[6:5]])))
        else $error("cmos read gate wrong");
    chk_bank_decode: assert property (p_bank)
        else $error("bank decode wrong");
    chk_kbd_select: assert property (p_kbd)
        else $error("keyboard select outputs wrong");
    chk_p12_polarity: assert property (disable iff (!i_rst_n)
        $past(i_ce) && $past(i_rst_n) && !$past(kbd_wr) |->
            o_kbd_port_line_twelve == ($past(i_kbd_reset_assert) ~^ pol_reg))
        else $error("port line twelve polarity wrong");
    chk_rsvd_zero: assert property (disable iff (!i_rst_n)
        rsv_rd |=> o_rdata == '0)
        else $error("reserved index read not zero");
    chk_pin_wake: assert property (disable iff (!i_vbat_rst_n)
        en_reg[`RKW_WK_RING_ONE] && $fell(i_ring_one_n) |-> ##[3:6] !o_power_on_request_n)
        else $error("ring wake did not request power");
    chk_alarm_wake: assert property (disable iff (!i_vbat_rst_n)
        en_reg[`RKW_WK_CLOCK_ALARM] && i_clock_alarm |-> ##[1:3] !o_power_on_request_n)
        else $error("alarm wake did not request power");
    chk_wake_blocked: assert property (disable iff (!i_vbat_rst_n)
        $past(en_reg) == 8'h00 && $past(en_reg, 2) == 8'h00 |-> o_power_on_request_n)
        else $error("power request with all sources off");

    cover property (disable iff (!i_rst_n) mode_wr && |i_wdata[3:0]);
    cover property (disable iff (!i_vbat_rst_n) en_reg[7] && i_clock_alarm);
    cover property (disable iff (!i_rst_n) rsv_rd);
endmodule

bind rkw_cfg_regs rkw_cfg_regs_properties #(.AW(AW), .DW(DW)) u_props (.*);
`default_nettype wire

/* File: dv/tb_rkw_cfg_regs.sv */
// Self-checking bench for the clock, keyboard and wake config registers
`timescale 1ns/1ps
`default_nettype none
module tb_rkw_cfg_regs;
    localparam logic [15:0] A_MODE = 16'h06F0;
    localparam logic [15:0] A_KBD  = 16'h07F0;
    localparam logic [15:0] A_EN   = 16'h08B0;
    localparam logic [15:0] A_STAT = 16'h08B2;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_vbat_rst_n = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_cmos_wr = 1'b0;
    logic        i_cmos_rd = 1'b0;
    logic        i_cmos_upper = 1'b0;
    logic [6:0]  i_cmos_off = 7'h00;
    logic        i_kbd_reset_assert = 1'b0;
    logic        i_ce = 1'b1;
    wire  [7:0]  o_lower_bank_base;
    logic [7:0]  src = 8'h00; // Active wake sources, in enable bit order
    wire  [7:0]  o_rdata;
    wire         o_cmos_wr_ok, o_cmos_rd_ok, o_lower_bank_en, o_upper_bank_en;
    wire         o_kbd_port_line_twelve, o_port92_en, o_addr20_gate_hw;
    wire         o_keyboard_reset_hw, o_power_on_request_n;
    int          num_errors = 0;
    int          checked = 0;

    always #4 i_mclk = ~i_mclk;

    rkw_cfg_regs DUT (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_vbat_rst_n(i_vbat_rst_n), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_cmos_wr(i_cmos_wr), .i_cmos_rd(i_cmos_rd), .i_cmos_upper(i_cmos_upper),
        .i_cmos_off(i_cmos_off), .o_cmos_wr_ok(o_cmos_wr_ok), .o_cmos_rd_ok(o_cmos_rd_ok),
        .o_lower_bank_en(o_lower_bank_en), .o_lower_bank_base(o_lower_bank_base),
        .o_upper_bank_en(o_upper_bank_en), .i_kbd_reset_assert(i_kbd_reset_assert),
        .o_kbd_port_line_twelve(o_kbd_port_line_twelve), .o_port92_en(o_port92_en),
        .o_addr20_gate_hw(o_addr20_gate_hw), .o_keyboard_reset_hw(o_keyboard_reset_hw),
        .i_ring_one_n(~src[0]), .i_ring_two_n(~src[1]), .i_kbd_clock(~src[2]),
        .i_mouse_clock(~src[3]), .i_ir_receive_pin(~src[6]), .i_group_int_one(src[4]),
        .i_group_int_two(src[5]), .i_clock_alarm(src[7]),
        .o_power_on_request_n(o_power_on_request_n)
    );

    // ********
    // Shared tasks
    // ********
    task automatic chk(input logic [7:0] seen, input logic [7:0] e);
        checked++;
        if (seen !== e) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(negedge i_mclk);
    endtask

    // Read data stands one cycle only, so it is sampled mid-cycle
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk(o_rdata, e);
    endtask

    task automatic cm(input logic up, input logic [6:0] off, input logic ok);
        @(posedge i_mclk);
        i_cmos_wr <= 1'b1;
        i_cmos_rd <= 1'b1;
        i_cmos_upper <= up;
        i_cmos_off <= off;
        @(negedge i_mclk);
        chk({7'h00, o_cmos_wr_ok}, {7'h00, ok});
        chk({7'h00, o_cmos_rd_ok}, {7'h00, ok});
    endtask

    task automatic pulse(input logic main, input logic bat);
        @(posedge i_mclk);
        i_rst_n <= !main;
        i_vbat_rst_n <= !bat;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        i_vbat_rst_n <= 1'b1;
        @(negedge i_mclk);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        rdc(A_MODE, 8'h00);
        rdc(A_KBD, 8'h00);
        rdc(A_EN, 8'h00);
        chk({6'h00, o_upper_bank_en, o_lower_bank_en}, 8'h02);
        chk({7'h00, o_kbd_port_line_twelve}, 8'h01);
        $display("reset values done");
    endtask

    task automatic t_bank;
        for (int b = 0; b < 4; b++) begin
            wr(A_MODE, 8'(b << 4));
            chk({6'h00, o_upper_bank_en, o_lower_bank_en}, {6'h00, ~b[1], b[0]});
            rdc(A_MODE, 8'(b << 4));
            chk(o_lower_bank_base, 8'h70);
        end
        $display("bank decode done");
    endtask

    task automatic t_lock;
        wr(A_EN, 8'h5A);
        for (int k = 0; k < 4; k++) begin
            wr(A_MODE, 8'(1 << k));
            for (int b = 0; b < 4; b++) begin
                cm(1'b1, 7'(b * 32 + 31), b > k);
                cm(1'b0, 7'(b * 32), 1'b1);
            end
        end
        wr(A_MODE, 8'h00);
        rdc(A_MODE, 8'h0F);
        pulse(1'b1, 1'b0);
        rdc(A_MODE, 8'h00);
        cm(1'b1, 7'h7F, 1'b1);
        rdc(A_EN, 8'h5A);
        pulse(1'b0, 1'b1);
        rdc(A_EN, 8'h00);
        $display("cmos lock done");
    endtask

    task automatic t_kbd;
        logic [7:0] v [4] = '{8'h01, 8'h02, 8'h04, 8'hF8};
        for (int i = 0; i < 4; i++) begin
            wr(A_KBD, v[i]);
            chk({5'h00, o_port92_en, o_addr20_gate_hw, o_keyboard_reset_hw},
                {5'h00, v[i][2:0]});
            rdc(A_KBD, v[i]);
            for (int a = 0; a < 2; a++) begin
                @(posedge i_mclk);
                i_kbd_reset_assert <= a[0];
                repeat (2) @(negedge i_mclk);
                chk({7'h00, o_kbd_port_line_twelve}, {7'h00, a[0] ~^ v[i][7]});
            end
        end
        $display("keyboard select done");
    endtask

    task automatic t_rsvd;
        wr(16'h07F5, 8'hA5);
        for (int x = 'hF1; x <= 'hFF; x++)
            rdc({8'h07, 8'(x)}, 8'h00);
        rdc(16'h09F0, 8'h00);
        // A write while the clock enable is low must leave the register alone
        @(posedge i_mclk);
        i_ce <= 1'b0;
        wr(A_KBD, 8'h00);
        @(posedge i_mclk);
        i_ce <= 1'b1;
        rdc(A_KBD, 8'hF8);
        $display("reserved indices done");
    endtask

    // Phase 0 enables all but the source, phase 1 only the source, phase 2 none
    task automatic t_wake;
        for (int i = 0; i < 8; i++) begin
            for (int ph = 0; ph < 3; ph++) begin
                wr(A_EN, (ph == 2) ? 8'h00 : (ph ? 8'(1 << i) : ~8'(1 << i)));
                @(posedge i_mclk);
                src <= 8'(1 << i);
                repeat (6) @(negedge i_mclk);
                chk({7'h00, o_power_on_request_n}, {7'h00, ph != 1});
                rdc(A_STAT, 8'(1 << i));
                @(posedge i_mclk);
                src <= 8'h00;
                repeat (4) @(negedge i_mclk);
                rdc(A_STAT, (i == 7) ? 8'h80 : 8'h00);
                repeat (2) @(negedge i_mclk);
                chk({7'h00, o_power_on_request_n}, 8'h01);
            end
        end
        $display("wake sources done");
    endtask

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Whole run is well under a thousand cycles; the 25000-cycle limit leaves a wide margin
    initial begin
        #200000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report;
    end

    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        i_vbat_rst_n <= 1'b1;
        t_reset;
        t_bank;
        t_lock;
        t_kbd;
        t_rsvd;
        t_wake;
        final_report;
    end
endmodule
`default_nettype wire
